// ==== logic/ur_uart_rx.sv ====
`timescale 1ns/1ps
`include "ur_consts.svh"
// How it works
// - sample line at 16x baud; edge is low after three highs
// - start kept if two of phases 3,5,7 low; start bit counts as low
// - each data and stop bit resolved by majority of phases 8,9,10
// - any disagreeing sample before the stop bit sets noise flag on transfer
// - edge search always runs; each falling edge realigns sample phase
// - framing error on non-break preloads edge history with three highs
// - while framing flag set, shifter runs but no transfer to buffer
// - sleep blocks receive flags except idle when idle-in-sleep enabled
// - idle wake mode clears sleep after 10 or 11 idle bit times
// - waking idle sets no idle flag unless idle-in-sleep enabled
// - idle count starts after start bit, or after stop when selected
// - address mark MSB clears sleep before stop; character is received
// - three interrupt outputs over ten individually masked sources
// - transmit interrupt held while empty or done flag high and enabled
// - buffer full clears by status read while high then data read
// - idle clears same way; rearms only after new buffer-full set
// - error flags set with buffer full; overrun drops data and errors
// - any active receive edge sets edge flag while rx on and not asleep; write one clears
// - ninth transmit bit copied with data; ninth receive bit kept
// - deep stop loses registers; light stop holds, edge detector wakes
// - internal loop feeds transmitter to receiver, receive pin freed
// - single-wire listens on tx pin; direction bit gates transmitter
// - frame is low start, 8 or 9 data bits LSB first, high stop
module ur_uart_rx (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [1:0] stopMode,
	input wire logic rxPin,
	input wire logic txPinIn,
	output logic txPinOut,
	output logic txPinOe,
	output logic rxPinFree,
	output logic txIrq,
	output logic rxIrq,
	output logic errIrq,
	output logic stopWake
);

	// ****************************************
	// declarations
	// ****************************************
	logic rstAll;
	logic run;
	logic busDone;
	logic wrEn;
	logic rdEn;
	logic [31:0] prdataNext;
	logic preadyNext;
	logic pslverrNext;
	ur_pkg::ur_ctrl_s ctrl_reg, ctrl_next;
	logic [9:0] mask_reg, mask_next;
	ur_pkg::ur_flags_s flags_reg, flags_next;
	ur_pkg::ur_flags_s flagsView;
	logic [15:0] baud_reg, baud_next;
	logic [15:0] baudCnt_reg, baudCnt_next;
	logic tick_reg, tick_next;
	logic [8:0] rxData_reg, rxData_next;
	logic rxNinth_reg, rxNinth_next;
	logic armRx_reg, armRx_next;
	logic armIdle_reg, armIdle_next;
	logic idleArm_reg, idleArm_next;
	logic txIrqNext;
	logic rxIrqNext;
	logic errIrqNext;
	logic stopWakeNext;
	logic rxPinFreeNext;
	// receiver state
	ur_pkg::ur_rx_e rxState_reg, rxState_next;
	logic [3:0] phase_reg, phase_next;
	logic [2:0] hist_reg, hist_next;
	logic [3:0] bitIdx_reg, bitIdx_next;
	logic [2:0] samp_reg, samp_next;
	logic noise_reg, noise_next;
	logic [8:0] shift_reg, shift_next;
	logic [7:0] idleCnt_reg, idleCnt_next;
	logic idleDone_reg, idleDone_next;
	logic rxPrev_reg;
	logic rxIn;
	logic sample;
	logic fall;
	logic bitVal;
	logic [3:0] lastData;
	logic charDone;
	logic charFrame;
	logic charBreak;
	logic charParity;
	logic idleHit;
	logic addrMark;
	logic edgeHit;
	logic idleCountOn;
	// transmitter state
	logic [7:0] txBuf_reg, txBuf_next;
	logic txBufFull_reg, txBufFull_next;
	logic [10:0] txSh_reg, txSh_next;
	logic [3:0] txBits_reg, txBits_next;
	logic [3:0] txTick_reg, txTick_next;
	logic txBusy_reg, txBusy_next;
	logic preamble_reg, preamble_next;
	logic txOnPrev_reg;
	logic txLine;
	logic txPinOutNext;
	logic txPinOeNext;

	// ****************************************
	// clocking and mode routing
	// ****************************************
	assign rstAll = reset | stopMode[1];
	assign run = (stopMode == `UR_STOP_RUN);
	assign busDone = psel & penable & pready;
	assign wrEn = busDone & pwrite;
	assign rdEn = busDone & ~pwrite;
	assign txLine = txBusy_reg ? txSh_reg[0] : 1'b1;
	// receive source: pin, internal loop, or the shared tx wire
	always_comb begin
		if (!ctrl_reg.internalLoopSelect) begin
			rxIn = rxPin;
		end else if (!ctrl_reg.rxSourceSelect) begin
			rxIn = txLine;
		end else begin
			rxIn = ctrl_reg.txPinDriveDir ? txLine : txPinIn;
		end
	end
	assign lastData = ctrl_reg.nineBit ? 4'h9 : 4'h8;
	assign edgeHit = ctrl_reg.rxOn & rxPrev_reg & ~rxIn;

	// ****************************************
	// apb slave, one wait state
	// ****************************************
	always_comb begin
		preadyNext = psel & penable & ~pready;
		pslverrNext = 1'b0;
		prdataNext = prdata;
		if (psel && penable && !pready) begin
			prdataNext = 32'h00000000;
			case (paddr)
				`UR_OFF_CTRL: prdataNext[`UR_CTRL_W-1:0] = ctrl_reg;
				`UR_OFF_MASK: prdataNext[`UR_FLAG_W-1:0] = mask_reg;
				`UR_OFF_STATUS: begin
					prdataNext[`UR_FLAG_W-1:0] = flagsView;
					prdataNext[`UR_ST_RXNINTH] = rxNinth_reg;
					prdataNext[`UR_ST_RXBUSY] = (rxState_reg == ur_pkg::RX_FRAME);
				end
				`UR_OFF_DATA: prdataNext[8:0] = rxData_reg;
				`UR_OFF_BAUD: prdataNext[15:0] = baud_reg;
				default: pslverrNext = 1'b1;
			endcase
		end
	end

	// ****************************************
	// 16x sample tick divider
	// ****************************************
	always_comb begin
		baudCnt_next = baudCnt_reg;
		tick_next = 1'b0;
		if (run) begin
			if (baudCnt_reg == 16'h0000) begin
				baudCnt_next = baud_reg - 16'h0001;
				tick_next = 1'b1;
			end else begin
				baudCnt_next = baudCnt_reg - 16'h0001;
			end
		end
	end

	// ****************************************
	// receiver: edge search, voting, framing
	// ****************************************
	always_comb begin
		rxState_next = rxState_reg;
		phase_next = phase_reg;
		hist_next = hist_reg;
		bitIdx_next = bitIdx_reg;
		samp_next = samp_reg;
		noise_next = noise_reg;
		shift_next = shift_reg;
		idleCnt_next = idleCnt_reg;
		idleDone_next = idleDone_reg;
		sample = rxIn;
		fall = (hist_reg == 3'h7) & ~rxIn;
		bitVal = (samp_reg[1] & samp_reg[0]) | (samp_reg[1] & rxIn) | (samp_reg[0] & rxIn);
		charDone = 1'b0;
		charFrame = 1'b0;
		charBreak = 1'b0;
		charParity = 1'b0;
		idleHit = 1'b0;
		addrMark = 1'b0;
		idleCountOn = ctrl_reg.idleCountStartSelect ? (rxState_reg == ur_pkg::RX_HUNT) :
			((rxState_reg == ur_pkg::RX_HUNT) || (bitIdx_reg != 4'h0));
		if (!ctrl_reg.rxOn) begin
			rxState_next = ur_pkg::RX_HUNT;
			idleCnt_next = 8'h00;
			idleDone_next = 1'b0;
		end else if (tick_reg) begin
			hist_next = {hist_reg[1:0], sample};
			// idle line measured in consecutive high samples
			if (!sample || !idleCountOn) begin
				idleCnt_next = 8'h00;
				idleDone_next = idleDone_reg & sample;
			end else if (!idleDone_reg) begin
				idleCnt_next = idleCnt_reg + 8'h01;
				if (idleCnt_next == (ctrl_reg.nineBit ? `UR_IDLE_TICKS_9 : `UR_IDLE_TICKS_8)) begin
					idleHit = 1'b1;
					idleDone_next = 1'b1;
				end
			end
			case (rxState_reg)
				ur_pkg::RX_HUNT: begin
					if (fall) begin
						rxState_next = ur_pkg::RX_FRAME;
						phase_next = 4'h1; // edge sample was the first phase
						bitIdx_next = 4'h0;
						noise_next = 1'b0;
					end
				end
				ur_pkg::RX_FRAME: begin
					phase_next = phase_reg + 4'h1;
					if (fall) begin
						phase_next = 4'h1;
					end else if (bitIdx_reg == 4'h0 && (phase_reg == `UR_PH_S3 ||
						phase_reg == `UR_PH_S5)) begin
						samp_next = {samp_reg[1:0], sample};
					end else if (bitIdx_reg == 4'h0 && phase_reg == `UR_PH_S7) begin
						// two or more lows keep the start bit
						if (bitVal) begin
							rxState_next = ur_pkg::RX_HUNT;
						end
						noise_next = noise_reg | (samp_reg[1] | samp_reg[0] | sample);
					end else if (phase_reg == `UR_PH_S8 || phase_reg == `UR_PH_S9) begin
						samp_next = {samp_reg[1:0], sample};
						if (bitIdx_reg == 4'h0) begin
							noise_next = noise_reg | sample;
						end
					end else if (phase_reg == `UR_PH_S10) begin
						// majority of three mid-bit samples
						if (bitIdx_reg != 4'h0) begin
							noise_next = noise_reg | (samp_reg[1] != bitVal) |
								(samp_reg[0] != bitVal) | (sample != bitVal);
						end else begin
							noise_next = noise_reg | sample;
						end
						if (bitIdx_reg != 4'h0 && bitIdx_reg <= lastData) begin
							shift_next[bitIdx_reg - 4'h1] = bitVal;
							if (bitIdx_reg == lastData && bitVal && ctrl_reg.addrWake) begin
								addrMark = 1'b1;
							end
						end else if (bitIdx_reg > lastData) begin
							charDone = 1'b1;
							charFrame = ~bitVal;
							charBreak = ~bitVal & (shift_reg == 9'h000);
							charParity = ctrl_reg.parityOn & ((^shift_reg) ^ ctrl_reg.parityOdd);
							rxState_next = ur_pkg::RX_HUNT;
							if (!bitVal && !charBreak) begin
								hist_next = 3'h7;
							end
						end
					end else if (phase_reg == `UR_PH_LAST) begin
						bitIdx_next = bitIdx_reg + 4'h1;
					end
				end
				default: rxState_next = ur_pkg::RX_HUNT;
			endcase
			if (rxState_reg == ur_pkg::RX_HUNT && fall) begin
				shift_next = 9'h000;
			end
		end
	end

	// ****************************************
	// transmitter: preamble, buffer, shifter
	// ****************************************
	always_comb begin
		txBuf_next = txBuf_reg;
		txBufFull_next = txBufFull_reg;
		txSh_next = txSh_reg;
		txBits_next = txBits_reg;
		txTick_next = txTick_reg;
		txBusy_next = txBusy_reg;
		preamble_next = preamble_reg | (ctrl_reg.txOn & ~txOnPrev_reg);
		if (wrEn && paddr == `UR_OFF_DATA) begin
			txBuf_next = pwdata[7:0];
			txBufFull_next = 1'b1;
		end
		if (tick_reg) begin
			if (txBusy_reg) begin
				txTick_next = txTick_reg + 4'h1;
				if (txTick_reg == `UR_PH_LAST) begin
					txSh_next = {1'b1, txSh_reg[10:1]};
					txBits_next = txBits_reg - 4'h1;
					txBusy_next = (txBits_reg != 4'h1);
				end
			end else if (ctrl_reg.txOn && preamble_reg) begin
				txSh_next = 11'h7ff;
				txBits_next = lastData + 4'h2;
				txTick_next = 4'h0;
				txBusy_next = 1'b1;
				preamble_next = 1'b0;
			end else if (ctrl_reg.txOn && txBufFull_reg) begin
				// ninth bit sits above the data byte when enabled
				txSh_next = {1'b1, ctrl_reg.nineBit ? ctrl_reg.txNinthBit : 1'b1,
					txBuf_reg, 1'b0};
				txBits_next = lastData + 4'h2;
				txTick_next = 4'h0;
				txBusy_next = 1'b1;
				txBufFull_next = 1'b0;
			end
		end
		// single-wire input direction releases the pin
		txPinOeNext = ~(ctrl_reg.internalLoopSelect & ctrl_reg.rxSourceSelect &
			~ctrl_reg.txPinDriveDir);
		txPinOutNext = txLine;
	end

	// ****************************************
	// control, flags, clear sequences, interrupts
	// ****************************************
	always_comb begin
		ctrl_next = ctrl_reg;
		mask_next = mask_reg;
		baud_next = baud_reg;
		flags_next = flags_reg;
		rxData_next = rxData_reg;
		rxNinth_next = rxNinth_reg;
		armRx_next = armRx_reg;
		armIdle_next = armIdle_reg;
		idleArm_next = idleArm_reg;
		flagsView = flags_reg;
		flagsView.txBufferEmptyFlag = ~txBufFull_reg;
		flagsView.txDoneFlag = ~txBufFull_reg & ~txBusy_reg & ~preamble_reg;
		if (wrEn) begin
			case (paddr)
				`UR_OFF_CTRL: ctrl_next = pwdata[`UR_CTRL_W-1:0];
				`UR_OFF_MASK: mask_next = pwdata[`UR_FLAG_W-1:0];
				`UR_OFF_BAUD: baud_next = (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
				`UR_OFF_STATUS: begin
					flags_next.rxEdgeFlag = flags_reg.rxEdgeFlag &
						~pwdata[`UR_FLAG_RXEDGE];
					flags_next.brkDetectFlag = flags_reg.brkDetectFlag & ~pwdata[`UR_FLAG_BRK];
				end
				default: ;
			endcase
		end
		// status read while high arms, data read clears
		if (rdEn && paddr == `UR_OFF_STATUS) begin
			armRx_next = flags_reg.rxBufferFullFlag;
			armIdle_next = flags_reg.idleFlag;
		end
		if (rdEn && paddr == `UR_OFF_DATA) begin
			if (armRx_reg) begin
				flags_next.rxBufferFullFlag = 1'b0;
				flags_next.noiseFlag = 1'b0;
				flags_next.frameErrorFlag = 1'b0;
				flags_next.parityErrorFlag = 1'b0;
				flags_next.overrunFlag = 1'b0;
			end
			if (armIdle_reg) begin
				flags_next.idleFlag = 1'b0;
			end
			armRx_next = 1'b0;
			armIdle_next = 1'b0;
		end
		// hardware sets below win over any clear above
		if (edgeHit && !ctrl_reg.rxSleepAsk) begin
			flags_next.rxEdgeFlag = 1'b1;
		end
		if (addrMark) begin
			ctrl_next.rxSleepAsk = 1'b0;
		end
		if (idleHit) begin
			if (!ctrl_reg.addrWake) begin
				ctrl_next.rxSleepAsk = 1'b0;
			end
			if (idleArm_reg && (!ctrl_reg.rxSleepAsk || ctrl_reg.idleInSleepEnable)) begin
				flags_next.idleFlag = 1'b1;
				idleArm_next = 1'b0;
			end
		end
		// a clear in this same cycle frees the buffer for the new character
		if (charDone && !ctrl_reg.rxSleepAsk && !flags_next.frameErrorFlag) begin
			if (flags_next.rxBufferFullFlag) begin
				flags_next.overrunFlag = 1'b1;
			end else begin
				rxData_next = shift_reg;
				rxNinth_next = shift_reg[8];
				flags_next.rxBufferFullFlag = 1'b1;
				flags_next.noiseFlag = noise_reg;
				flags_next.frameErrorFlag = charFrame;
				flags_next.parityErrorFlag = charParity;
				flags_next.brkDetectFlag = flags_next.brkDetectFlag | charBreak;
				idleArm_next = 1'b1;
			end
		end
		// three grouped requests, ten masks
		txIrqNext = |(mask_reg[1:0] & {flagsView.txDoneFlag, flagsView.txBufferEmptyFlag});
		rxIrqNext = |(mask_reg[5:2] & {flagsView.brkDetectFlag, flagsView.rxEdgeFlag,
			flagsView.idleFlag, flagsView.rxBufferFullFlag});
		errIrqNext = |(mask_reg[9:6] & {flagsView.parityErrorFlag, flagsView.frameErrorFlag,
			flagsView.noiseFlag, flagsView.overrunFlag});
		stopWakeNext = (stopMode == `UR_STOP_LIGHT) & flags_reg.rxEdgeFlag &
			mask_reg[`UR_FLAG_RXEDGE];
		rxPinFreeNext = ctrl_reg.internalLoopSelect;
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge core_clk) begin
		if (rstAll) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			ctrl_reg <= `UR_CTRL_RST;
			mask_reg <= `UR_MASK_RST;
			flags_reg <= '0;
			baud_reg <= `UR_BAUD_RST;
			baudCnt_reg <= 16'h0000;
			tick_reg <= 1'b0;
			rxData_reg <= 9'h000;
			rxNinth_reg <= 1'b0;
			armRx_reg <= 1'b0;
			armIdle_reg <= 1'b0;
			idleArm_reg <= 1'b0;
			rxState_reg <= ur_pkg::RX_HUNT;
			phase_reg <= 4'h0;
			hist_reg <= 3'h0;
			bitIdx_reg <= 4'h0;
			samp_reg <= 3'h0;
			noise_reg <= 1'b0;
			shift_reg <= 9'h000;
			idleCnt_reg <= 8'h00;
			idleDone_reg <= 1'b0;
			rxPrev_reg <= 1'b1;
			txBuf_reg <= 8'h00;
			txBufFull_reg <= 1'b0;
			txSh_reg <= 11'h7ff;
			txBits_reg <= 4'h0;
			txTick_reg <= 4'h0;
			txBusy_reg <= 1'b0;
			preamble_reg <= 1'b0;
			txOnPrev_reg <= 1'b0;
			txPinOut <= 1'b1;
			txPinOe <= 1'b1;
			rxPinFree <= 1'b0;
			txIrq <= 1'b0;
			rxIrq <= 1'b0;
			errIrq <= 1'b0;
			stopWake <= 1'b0;
		end else begin
			prdata <= prdataNext;
			pready <= preadyNext;
			pslverr <= pslverrNext;
			rxPrev_reg <= rxIn; // edge detector runs in light stop too
			flags_reg <= flags_next;
			stopWake <= stopWakeNext;
			ctrl_reg <= ctrl_next;
			mask_reg <= mask_next;
			baud_reg <= baud_next;
			rxData_reg <= rxData_next;
			rxNinth_reg <= rxNinth_next;
			armRx_reg <= armRx_next;
			armIdle_reg <= armIdle_next;
			idleArm_reg <= idleArm_next;
			baudCnt_reg <= baudCnt_next;
			tick_reg <= tick_next;
			rxState_reg <= rxState_next;
			phase_reg <= phase_next;
			hist_reg <= hist_next;
			bitIdx_reg <= bitIdx_next;
			samp_reg <= samp_next;
			noise_reg <= noise_next;
			shift_reg <= shift_next;
			idleCnt_reg <= idleCnt_next;
			idleDone_reg <= idleDone_next;
			txBuf_reg <= txBuf_next;
			txBufFull_reg <= txBufFull_next;
			txSh_reg <= txSh_next;
			txBits_reg <= txBits_next;
			txTick_reg <= txTick_next;
			txBusy_reg <= txBusy_next;
			preamble_reg <= preamble_next;
			txOnPrev_reg <= ctrl_reg.txOn;
			txPinOut <= txPinOutNext;
			txPinOe <= txPinOeNext;
			rxPinFree <= rxPinFreeNext;
			txIrq <= txIrqNext;
			rxIrq <= rxIrqNext;
			errIrq <= errIrqNext;
		end
	end

endmodule

// ==== logic/ur_consts.svh ====
`ifndef UR_CONSTS_SVH
`define UR_CONSTS_SVH

// ****************************************
// register byte offsets
// ****************************************
`define UR_OFF_CTRL 8'h00
`define UR_OFF_MASK 8'h04
`define UR_OFF_STATUS 8'h08
`define UR_OFF_DATA 8'h0c
`define UR_OFF_BAUD 8'h10

// ****************************************
// field positions and reset values
// ****************************************
`define UR_CTRL_W 13
`define UR_FLAG_W 10
`define UR_ST_RXNINTH 10
`define UR_ST_RXBUSY 11
`define UR_FLAG_RXEDGE 4
`define UR_FLAG_BRK 5
`define UR_CTRL_RST 13'h0000
`define UR_MASK_RST 10'h000
`define UR_BAUD_RST 16'h0036

// ****************************************
// timing counts, in 16x sample ticks, and stop mode codes
// ****************************************
`define UR_PH_S3 4'h2
`define UR_PH_S5 4'h4
`define UR_PH_S7 4'h6
`define UR_PH_S8 4'h7
`define UR_PH_S9 4'h8
`define UR_PH_S10 4'h9
`define UR_PH_LAST 4'hf
`define UR_IDLE_TICKS_8 8'ha0
`define UR_IDLE_TICKS_9 8'hb0
`define UR_STOP_RUN 2'h0
`define UR_STOP_LIGHT 2'h1

`endif

// ==== logic/ur_pkg.sv ====
package ur_pkg;

	// control register fields, bit 0 is rxOn
	typedef struct packed {
		logic txNinthBit;
		logic txPinDriveDir;
		logic rxSourceSelect;
		logic internalLoopSelect;
		logic idleInSleepEnable;
		logic rxSleepAsk;
		logic idleCountStartSelect;
		logic addrWake;
		logic nineBit;
		logic parityOdd;
		logic parityOn;
		logic txOn;
		logic rxOn;
	} ur_ctrl_s;

	// status flags, same order as the mask bits
	typedef struct packed {
		logic parityErrorFlag;
		logic frameErrorFlag;
		logic noiseFlag;
		logic overrunFlag;
		logic brkDetectFlag;
		logic rxEdgeFlag;
		logic idleFlag;
		logic rxBufferFullFlag;
		logic txDoneFlag;
		logic txBufferEmptyFlag;
	} ur_flags_s;

	typedef enum logic {RX_HUNT, RX_FRAME} ur_rx_e;

endpackage

// ==== dv/ur_uart_rx_monitor.sv ====
`timescale 1ns/1ps
// ****************************************
// port checker for the serial receiver
// ****************************************
module ur_uart_rx_monitor (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [1:0] stopMode,
	input wire logic rxPin,
	input wire logic txPinIn,
	input wire logic txPinOut,
	input wire logic txPinOe,
	input wire logic rxPinFree,
	input wire logic txIrq,
	input wire logic rxIrq,
	input wire logic errIrq,
	input wire logic stopWake
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (reset);

	// bus answer timing and refusal
	a_ready_after: assert property (psel && penable && !pready |=> pready)
		else $error("pready missing after access phase");
	a_ready_single: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	a_ready_idle: assert property (!psel |=> !pready)
		else $error("pready without a selected transfer");
	a_err_unmapped: assert property (pready |->
		(pslverr == ((paddr > 8'h10) || (paddr[1:0] != 2'h0))))
		else $error("pslverr does not match address map");
	a_err_rdata: assert property (pready && pslverr |-> prdata == 32'h0)
		else $error("refused read returned data");

	// stop mode behaviour
	a_wake_light: assert property (stopWake |-> $past(stopMode) == 2'h1)
		else $error("stop wake outside light stop");
	a_deep_clear: assert property (stopMode[1] |=> !txIrq && !rxIrq && !errIrq
		&& !stopWake && !rxPinFree && txPinOut && txPinOe)
		else $error("deep stop did not clear state");
	a_light_hold: assert property (stopMode == 2'h1 && $past(stopMode) == 2'h1
		|-> $stable(txPinOut) && $stable(errIrq) && $stable(txIrq))
		else $error("outputs moved during light stop");

	c_refused: cover property (pready && pslverr);
	c_err_irq: cover property ($rose(errIrq));
	c_wake: cover property ($rose(stopWake));
endmodule

bind ur_uart_rx ur_uart_rx_monitor mon (.core_clk(core_clk), .reset(reset), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .stopMode(stopMode), .rxPin(rxPin),
	.txPinIn(txPinIn), .txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinFree(rxPinFree),
	.txIrq(txIrq), .rxIrq(rxIrq), .errIrq(errIrq), .stopWake(stopWake));

// ==== dv/ur_remote.sv ====
`timescale 1ns/1ps
// ****************************************
// remote serial transmitter on two lines
// ****************************************
module ur_remote #(
	parameter int BIT = 16
) (
	input wire logic core_clk,
	output logic rxLine,
	output logic wireLine
);
	// both lines rest at the pull-up level
	initial begin
		rxLine = 1'b1;
		wireLine = 1'b1;
	end

	// one frame, start low, data lsb first, then stop; optional one-tick glitch
	task automatic sendFrame(input logic sel, input logic [8:0] d, input int nb,
		input logic stopBit, input int glitch);
		logic bv;
		logic v;
		for (int i = 0; i < nb + 2; i++) begin
			bv = (i == 0) ? 1'b0 : ((i > nb) ? stopBit : d[i-1]);
			for (int t = 0; t < BIT; t++) begin
				@(posedge core_clk);
				v = (i == glitch && t == 8) ? ~bv : bv;
				if (sel) wireLine <= v;
				else rxLine <= v;
			end
		end
		@(posedge core_clk);
		rxLine <= 1'b1;
		wireLine <= 1'b1;
	endtask
endmodule

// ==== dv/tb_ur_uart_rx.sv ====
`timescale 1ns/1ps
`include "ur_consts.svh"
module tb_ur_uart_rx;
	logic core_clk, reset, psel, penable, pwrite, pready, pslverr, rxPin, txPinIn, remWire;
	logic txPinOut, txPinOe, rxPinFree, txIrq, rxIrq, errIrq, stopWake, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [1:0] stopMode;
	int error_cnt, checked;
	localparam logic [7:0] offCtrl = `UR_OFF_CTRL;
	localparam logic [7:0] offMask = `UR_OFF_MASK;
	localparam logic [7:0] offSt = `UR_OFF_STATUS;
	localparam logic [7:0] offData = `UR_OFF_DATA;

	ur_uart_rx dut (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .stopMode(stopMode), .rxPin(rxPin), .txPinIn(txPinIn),
		.txPinOut(txPinOut), .txPinOe(txPinOe), .rxPinFree(rxPinFree), .txIrq(txIrq),
		.rxIrq(rxIrq), .errIrq(errIrq), .stopWake(stopWake));
	ur_remote #(.BIT(16)) rem (.core_clk(core_clk), .rxLine(rxPin), .wireLine(remWire));
	// shared tx wire: the block wins while it drives
	assign txPinIn = txPinOe ? txPinOut : remWire;

	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// one bus transfer, held until pready is seen
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin error_cnt++; $display("ERROR pready exp 1 got %b", pready); end
		rd = prdata; er = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin error_cnt++; $display("ERROR %s exp %h got %h", nm, e, g); end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd & m);
	endtask
	task automatic wb(input int n);
		repeat (n * 16) @(posedge core_clk);
		#1;
	endtask
	task automatic final_report;
		$display("checks %0d errors %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	// watchdog
	initial begin
		repeat (60000) @(posedge core_clk);
		error_cnt++;
		final_report;
	end

	// main sequence
	initial begin
		reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
		pwdata = 32'h0; stopMode = 2'h0; error_cnt = 0; checked = 0;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		rdchk(offCtrl, 32'hffffffff, 32'h0, "ctrl reset");
		rdchk(`UR_OFF_BAUD, 32'hffffffff, 32'h36, "baud reset");
		apb(1'b0, 8'h14, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, `UR_OFF_BAUD, 32'h1);
		apb(1'b1, offCtrl, 32'h1);
		apb(1'b1, offMask, 32'h3ff);
		wb(4); // old divider count runs out before ticks come every cycle
		$display("registers done");
		rem.sendFrame(1'b0, 9'ha5, 8, 1'b1, -1);
		wb(12);
		rdchk(offSt, 32'h9c, 32'h1c, "full idle edge");
		chk("rx irq", 32'h1, {31'h0, rxIrq});
		rdchk(offData, 32'h1ff, 32'ha5, "data");
		rdchk(offSt, 32'hc, 32'h0, "full idle clear");
		wb(12);
		rdchk(offSt, 32'h8, 32'h0, "idle no rearm");
		apb(1'b1, offSt, 32'h10);
		rdchk(offSt, 32'h10, 32'h0, "edge w1c");
		$display("receive done");
		rem.sendFrame(1'b0, 9'h3c, 8, 1'b1, 1);
		wb(1);
		rdchk(offSt, 32'h84, 32'h84, "noise");
		rdchk(offData, 32'h1ff, 32'h3c, "noise data");
		rem.sendFrame(1'b0, 9'h11, 8, 1'b1, -1);
		rem.sendFrame(1'b0, 9'h22, 8, 1'b1, -1);
		wb(1);
		chk("err irq", 32'h1, {31'h0, errIrq});
		rdchk(offSt, 32'h1c4, 32'h44, "overrun");
		rdchk(offData, 32'h1ff, 32'h11, "overrun data");
		wb(1);
		chk("err irq off", 32'h0, {31'h0, errIrq});
		chk("tx irq", 32'h1, {31'h0, txIrq});
		apb(1'b1, offMask, 32'h3fc);
		wb(1);
		chk("tx irq masked", 32'h0, {31'h0, txIrq});
		$display("errors done");
		rem.sendFrame(1'b0, 9'h55, 8, 1'b0, -1);
		rem.sendFrame(1'b0, 9'h66, 8, 1'b1, -1);
		wb(1);
		rdchk(offSt, 32'h1c4, 32'h104, "frame");
		rdchk(offData, 32'h1ff, 32'h55, "frame data");
		$display("framing done");
		apb(1'b1, offCtrl, 32'ha1);
		rem.sendFrame(1'b0, 9'h12, 8, 1'b1, -1);
		wb(1);
		rdchk(offSt, 32'h4, 32'h0, "sleep drop");
		rem.sendFrame(1'b0, 9'h85, 8, 1'b1, -1);
		wb(1);
		rdchk(offCtrl, 32'h80, 32'h0, "mark wake");
		rdchk(offSt, 32'h4, 32'h4, "mark full");
		rdchk(offData, 32'h1ff, 32'h85, "mark data");
		apb(1'b1, offCtrl, 32'h81);
		wb(12);
		rdchk(offCtrl, 32'h80, 32'h0, "idle wake");
		rdchk(offSt, 32'h8, 32'h0, "wake no idle");
		$display("wake done");
		apb(1'b1, offCtrl, 32'h1213);
		wb(1);
		chk("rx pin free", 32'h1, {31'h0, rxPinFree});
		fork
			rem.sendFrame(1'b0, 9'h0ff, 9, 1'b1, -1);
		join_none
		apb(1'b1, offData, 32'h5a);
		wb(24);
		chk("tx line idle", 32'h1, {31'h0, txPinOut});
		rdchk(offSt, 32'h404, 32'h404, "ninth");
		rdchk(offData, 32'h1ff, 32'h15a, "loop data");
		apb(1'b1, offCtrl, 32'h613);
		wb(1);
		chk("tx pin released", 32'h0, {31'h0, txPinOe});
		rem.sendFrame(1'b1, 9'h1c3, 9, 1'b1, -1);
		wb(1);
		rdchk(offData, 32'h1ff, 32'h1c3, "wire data");
		$display("routing done");
		apb(1'b1, offCtrl, 32'h1);
		apb(1'b1, offSt, 32'h10);
		@(posedge core_clk);
		stopMode <= 2'h1;
		rem.sendFrame(1'b0, 9'h0, 8, 1'b1, -1);
		wb(1);
		chk("stop wake", 32'h1, {31'h0, stopWake});
		@(posedge core_clk);
		stopMode <= 2'h0;
		rdchk(offCtrl, 32'hffffffff, 32'h1, "light kept");
		@(posedge core_clk);
		stopMode <= 2'h2;
		@(posedge core_clk);
		stopMode <= 2'h0;
		rdchk(offCtrl, 32'hffffffff, 32'h0, "deep lost");
		$display("stop done");
		final_report;
	end
endmodule
